// ===== logic/rmc_pkg.sv
// -----------------------------------------------------------------
// Rendering mode control constants
// -----------------------------------------------------------------
package rmc_pkg;
   // Register indices and byte addresses (index times four)
   localparam logic [11:0] RMC_MODE_IDX = 12'h00C;
   localparam logic [11:0] RMC_STAT_IDX = 12'h00D;
   localparam logic [11:0] RMC_MODE_ADDR = {RMC_MODE_IDX[9:0], 2'b00};
   localparam logic [11:0] RMC_STAT_ADDR = {RMC_STAT_IDX[9:0], 2'b00};
   // Mode register field positions
   localparam int RMC_DRAWING_ADDR_SELECT_BIT = 15;
   localparam int RMC_MWX_BIT = 6;
   localparam int RMC_GBM_LSB = 0;
   localparam int RMC_GBM_W = 3;
   // Read mask of the mode register, reserved bits zero
   localparam logic [15:0] RMC_MODE_MASK = 16'h8047;
   // Status register field positions
   localparam int RMC_ST_HOSTWR_BIT = 0;
   localparam int RMC_ST_DLVIOL_BIT = 1;
   localparam int RMC_ST_CONFLICT_BIT = 2;
   localparam int RMC_ST_BUSY_BIT = 3;
   // Reset values of resettable fields
   localparam logic RMC_DRAWING_ADDR_SELECT_RST = 1'b0;
   localparam logic RMC_STICKY_RST = 1'b0;
   // Logical widths of graphics memory in pixels
   localparam logic [10:0] RMC_WIDTH_NARROW = 11'h200;
   localparam logic [10:0] RMC_WIDTH_WIDE = 11'h400;
   // Start address width
   localparam int RMC_ADDR_W = 24;
endpackage : rmc_pkg

// ===== logic/rmc_depth_dec.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Pixel depth decoder
// -----------------------------------------------------------------
module rmc_depth_dec (
   // Mode field
   input wire logic [2:0] pixel_depth_mode_i,
   // Depth flags, high means 16 bits per pixel, then the drawing address need flag (depth mode bit 2)
   output logic fg_16bpp_o,
   output logic bg_16bpp_o,
   output logic render_16bpp_o,
   output logic need_drawing_addr_o
);
   // Depth table lookup
   always_comb begin
      fg_16bpp_o = pixel_depth_mode_i[0];
      bg_16bpp_o = pixel_depth_mode_i[1] ^ pixel_depth_mode_i[0];
      // Bit 2 flips the rendering depth away from the foreground depth
      render_16bpp_o = pixel_depth_mode_i[0] ^ pixel_depth_mode_i[2];
      need_drawing_addr_o = pixel_depth_mode_i[2];
   end
endmodule : rmc_depth_dec

// ===== logic/rmc_top.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Bit 15 clear draws from the display start address, set draws from the drawing start address.
// RULE_02 - Software keeps the depth mode at 000 or 001 while the address select bit is clear.
// RULE_03 - Software sets the address select bit for depth modes 100 to 111.
// RULE_04 - Bit 6 picks a logical width of 512 pixels when clear and 1024 when set.
// RULE_05 - The three-bit depth mode decodes to foreground, background and rendering depths per the table.
// RULE_06 - Reset clears the address select bit and leaves width and depth mode untouched.
// RULE_07 - The host does not rewrite the mode register during drawing; only display-list writes may.
// RULE_08 - A display-list write during drawing leaves the width bit unchanged.
// RULE_09 - A display-list write during drawing changes only the rendering depth, not display depths.
// RULE_10 - A display-list write during drawing may change the address select bit consistently.
// RULE_11 - Software writes zeros to bits 14 to 7 and 5 to 3.
// RULE_12 - Reserved mode bits read as zero and ignore writes.
module rmc_top (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Display-list register write command
   input wire logic dl_wr_i,
   input wire logic [15:0] dl_wdata_i,
   // Drawing engine status and start addresses
   input wire logic drawing_busy_i,
   input wire logic [rmc_pkg::RMC_ADDR_W-1:0] display_start_addr_i,
   input wire logic [rmc_pkg::RMC_ADDR_W-1:0] drawing_start_addr_i,
   // Rendering configuration
   output logic drawing_addr_select_o,
   output logic memory_width_select_o,
   output logic [2:0] pixel_depth_mode_o,
   output logic [10:0] logical_width_o,
   output logic [rmc_pkg::RMC_ADDR_W-1:0] draw_base_addr_o,
   output logic fg_16bpp_o,
   output logic bg_16bpp_o,
   output logic render_16bpp_o,
   output logic config_conflict_o
);

   // -----------------------------------------------------------------
   // State
   // -----------------------------------------------------------------
   typedef struct packed {
      logic drawing_addr_select;
      logic memory_width_select;
      logic [2:0] pixel_depth_mode;
      logic host_wr_busy;
      logic dl_violation;
      logic [31:0] rdata;
      logic [rmc_pkg::RMC_ADDR_W-1:0] base_addr;
   } rmc_state_s;

   rmc_state_s state_ff;
   rmc_state_s nxt_state;

   logic setup_phase;
   logic access_phase;
   logic hit_mode;
   logic hit_stat;
   logic host_wr_mode;
   logic host_wr_stat;
   logic need_drawing_addr;
   logic [15:0] mode_word;
   logic [31:0] stat_word;
   logic dl_bad;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   // Phases and address hits
   assign setup_phase = psel_i & ~penable_i;
   assign access_phase = psel_i & penable_i;
   assign hit_mode = (paddr_i == rmc_pkg::RMC_MODE_ADDR);
   assign hit_stat = (paddr_i == rmc_pkg::RMC_STAT_ADDR);
   assign host_wr_mode = access_phase & pwrite_i & hit_mode;
   assign host_wr_stat = access_phase & pwrite_i & hit_stat;

   // Zero-wait answer, error on unmapped address
   assign pready_o = 1'b1;
   assign pslverr_o = access_phase & ~(hit_mode | hit_stat);
   assign prdata_o = state_ff.rdata;

   // -----------------------------------------------------------------
   // Read words
   // -----------------------------------------------------------------
   // RULE_12 reserved read zero
   always_comb begin
      mode_word = 16'h0000;
      mode_word[rmc_pkg::RMC_DRAWING_ADDR_SELECT_BIT] = state_ff.drawing_addr_select;
      mode_word[rmc_pkg::RMC_MWX_BIT] = state_ff.memory_width_select;
      mode_word[rmc_pkg::RMC_GBM_LSB +: rmc_pkg::RMC_GBM_W] = state_ff.pixel_depth_mode;
      stat_word = 32'h0000_0000;
      stat_word[rmc_pkg::RMC_ST_HOSTWR_BIT] = state_ff.host_wr_busy;
      stat_word[rmc_pkg::RMC_ST_DLVIOL_BIT] = state_ff.dl_violation;
      stat_word[rmc_pkg::RMC_ST_CONFLICT_BIT] = config_conflict_o;
      stat_word[rmc_pkg::RMC_ST_BUSY_BIT] = drawing_busy_i;
   end

   // Display-list write that breaks the in-drawing limits
   assign dl_bad = dl_wr_i & drawing_busy_i &
                   ((dl_wdata_i[rmc_pkg::RMC_MWX_BIT] != state_ff.memory_width_select) |
                    (dl_wdata_i[1:0] != state_ff.pixel_depth_mode[1:0]));

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      // Read data captured in the setup cycle
      if (setup_phase && !pwrite_i) begin
         if (hit_mode) begin
            nxt_state.rdata = {16'h0000, mode_word};
         end else if (hit_stat) begin
            nxt_state.rdata = stat_word;
         end else begin
            nxt_state.rdata = 32'h0000_0000;
         end
      end
      // RULE_12 reserved writes dropped, display list wins a clash
      if (dl_wr_i) begin
         nxt_state.drawing_addr_select = dl_wdata_i[rmc_pkg::RMC_DRAWING_ADDR_SELECT_BIT];
         nxt_state.memory_width_select = dl_wdata_i[rmc_pkg::RMC_MWX_BIT];
         nxt_state.pixel_depth_mode = dl_wdata_i[rmc_pkg::RMC_GBM_LSB +: rmc_pkg::RMC_GBM_W];
      end else if (host_wr_mode) begin
         nxt_state.drawing_addr_select = pwdata_i[rmc_pkg::RMC_DRAWING_ADDR_SELECT_BIT];
         nxt_state.memory_width_select = pwdata_i[rmc_pkg::RMC_MWX_BIT];
         nxt_state.pixel_depth_mode = pwdata_i[rmc_pkg::RMC_GBM_LSB +: rmc_pkg::RMC_GBM_W];
      end
      // Sticky flags, write one to clear, set wins
      if (host_wr_stat && pwdata_i[rmc_pkg::RMC_ST_HOSTWR_BIT]) begin
         nxt_state.host_wr_busy = 1'b0;
      end
      if (host_wr_stat && pwdata_i[rmc_pkg::RMC_ST_DLVIOL_BIT]) begin
         nxt_state.dl_violation = 1'b0;
      end
      // RULE_07 flag host write during drawing
      if (host_wr_mode && drawing_busy_i) begin
         nxt_state.host_wr_busy = 1'b1;
      end
      // RULE_08 RULE_09 flag illegal list write
      if (dl_bad) begin
         nxt_state.dl_violation = 1'b1;
      end
      // RULE_01 drawing origin select
      nxt_state.base_addr = state_ff.drawing_addr_select ? drawing_start_addr_i : display_start_addr_i;
   end

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   // RULE_06 select bit, flags, read data and base address reset, width and depth kept
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff.drawing_addr_select <= rmc_pkg::RMC_DRAWING_ADDR_SELECT_RST;
         state_ff.host_wr_busy <= rmc_pkg::RMC_STICKY_RST;
         state_ff.dl_violation <= rmc_pkg::RMC_STICKY_RST;
         state_ff.rdata <= 32'h0000_0000;
         state_ff.base_addr <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // -----------------------------------------------------------------
   // Configuration outputs
   // -----------------------------------------------------------------
   // RULE_05 depth decode
   rmc_depth_dec u_depth (
      .pixel_depth_mode_i(state_ff.pixel_depth_mode),
      .fg_16bpp_o(fg_16bpp_o),
      .bg_16bpp_o(bg_16bpp_o),
      .render_16bpp_o(render_16bpp_o),
      .need_drawing_addr_o(need_drawing_addr)
   );

   assign drawing_addr_select_o = state_ff.drawing_addr_select;
   assign memory_width_select_o = state_ff.memory_width_select;
   assign pixel_depth_mode_o = state_ff.pixel_depth_mode;
   // RULE_04 logical width select
   assign logical_width_o = state_ff.memory_width_select ? rmc_pkg::RMC_WIDTH_WIDE : rmc_pkg::RMC_WIDTH_NARROW;
   // RULE_03 mixed-depth mode without separate origin
   assign config_conflict_o = need_drawing_addr & ~state_ff.drawing_addr_select;
   assign draw_base_addr_o = state_ff.base_addr;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   property p_origin_sel;
      @(posedge mclk_i) disable iff (rst_i)
      !$past(rst_i) |-> (draw_base_addr_o == ($past(drawing_addr_select_o) ? $past(drawing_start_addr_i)
                                              : $past(display_start_addr_i)));
   endproperty
   a_origin_sel: assert property (p_origin_sel) else $error("draw base address does not follow select bit"); // RULE_01

   property p_width;
      @(posedge mclk_i) disable iff (rst_i)
      (memory_width_select_o |-> logical_width_o == 11'h400)
      and (!memory_width_select_o |-> logical_width_o == 11'h200);
   endproperty
   a_width: assert property (p_width) else $error("logical width wrong for width bit"); // RULE_04

   property p_depth;
      @(posedge mclk_i) disable iff (rst_i)
      (pixel_depth_mode_o == 3'h4) |-> (!fg_16bpp_o && !bg_16bpp_o && render_16bpp_o);
   endproperty
   a_depth: assert property (p_depth) else $error("mode 100 depths wrong"); // RULE_05

   property p_depth_b;
      @(posedge mclk_i) disable iff (rst_i)
      (pixel_depth_mode_o == 3'h7) |-> (fg_16bpp_o && !bg_16bpp_o && !render_16bpp_o);
   endproperty
   a_depth_b: assert property (p_depth_b) else $error("mode 111 depths wrong"); // RULE_05

   property p_depth_m0;
      @(posedge mclk_i) disable iff (rst_i)
      (pixel_depth_mode_o == 3'h0) |-> (!fg_16bpp_o && !bg_16bpp_o && !render_16bpp_o);
   endproperty
   a_depth_m0: assert property (p_depth_m0) else $error("mode 000 depths wrong"); // RULE_05

   property p_depth_m1;
      @(posedge mclk_i) disable iff (rst_i)
      (pixel_depth_mode_o == 3'h1) |-> (fg_16bpp_o && bg_16bpp_o && render_16bpp_o);
   endproperty
   a_depth_m1: assert property (p_depth_m1) else $error("mode 001 depths wrong"); // RULE_05

   property p_depth_m2;
      @(posedge mclk_i) disable iff (rst_i)
      (pixel_depth_mode_o == 3'h2) |-> (!fg_16bpp_o && bg_16bpp_o && !render_16bpp_o);
   endproperty
   a_depth_m2: assert property (p_depth_m2) else $error("mode 010 depths wrong"); // RULE_05

   property p_depth_m3;
      @(posedge mclk_i) disable iff (rst_i)
      (pixel_depth_mode_o == 3'h3) |-> (fg_16bpp_o && !bg_16bpp_o && render_16bpp_o);
   endproperty
   a_depth_m3: assert property (p_depth_m3) else $error("mode 011 depths wrong"); // RULE_05

   property p_depth_m5;
      @(posedge mclk_i) disable iff (rst_i)
      (pixel_depth_mode_o == 3'h5) |-> (fg_16bpp_o && bg_16bpp_o && !render_16bpp_o);
   endproperty
   a_depth_m5: assert property (p_depth_m5) else $error("mode 101 depths wrong"); // RULE_05

   property p_depth_m6;
      @(posedge mclk_i) disable iff (rst_i)
      (pixel_depth_mode_o == 3'h6) |-> (!fg_16bpp_o && bg_16bpp_o && render_16bpp_o);
   endproperty
   a_depth_m6: assert property (p_depth_m6) else $error("mode 110 depths wrong"); // RULE_05

   property p_conflict;
      @(posedge mclk_i) disable iff (rst_i)
      (pixel_depth_mode_o[2] && !drawing_addr_select_o) |-> config_conflict_o;
   endproperty
   a_conflict: assert property (p_conflict) else $error("mixed depth without separate origin not flagged"); // RULE_03

   property p_host_busy;
      @(posedge mclk_i) disable iff (rst_i)
      (host_wr_mode && drawing_busy_i) |=> state_ff.host_wr_busy;
   endproperty
   a_host_busy: assert property (p_host_busy) else $error("host write during drawing not flagged"); // RULE_07

   property p_dl_write;
      @(posedge mclk_i) disable iff (rst_i)
      dl_wr_i |=> (drawing_addr_select_o == $past(dl_wdata_i[15]) && memory_width_select_o == $past(dl_wdata_i[6])
                   && pixel_depth_mode_o == $past(dl_wdata_i[2:0]));
   endproperty
   a_dl_write: assert property (p_dl_write) else $error("list write not stored"); // RULE_10

   property p_reset_drawing_addr_select;
      @(posedge mclk_i) disable iff (rst_i)
      $past(rst_i) |-> !drawing_addr_select_o;
   endproperty
   a_reset_drawing_addr_select: assert property (p_reset_drawing_addr_select) else $error("select bit not clear after reset"); // RULE_06

   property p_host_write;
      @(posedge mclk_i) disable iff (rst_i)
      (host_wr_mode && !dl_wr_i) |=> (pixel_depth_mode_o == $past(pwdata_i[2:0])
                                     && memory_width_select_o == $past(pwdata_i[6]));
   endproperty
   a_host_write: assert property (p_host_write) else $error("host write not stored"); // RULE_01

   property p_reserved;
      @(posedge mclk_i) disable iff (rst_i)
      (setup_phase && !pwrite_i && hit_mode) |=> (prdata_o[31:16] == 16'h0000 && prdata_o[14:7] == 8'h00
                                                 && prdata_o[5:3] == 3'h0);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode bits read nonzero"); // RULE_12

   property p_dl_flag;
      @(posedge mclk_i) disable iff (rst_i)
      dl_bad |=> state_ff.dl_violation;
   endproperty
   a_dl_flag: assert property (p_dl_flag) else $error("illegal list write not flagged"); // RULE_08

   c_dl_write: cover property (@(posedge mclk_i) disable iff (rst_i) dl_wr_i && drawing_busy_i);
   c_wide_sep: cover property (@(posedge mclk_i) disable iff (rst_i) memory_width_select_o && drawing_addr_select_o);
   c_conflict: cover property (@(posedge mclk_i) disable iff (rst_i) config_conflict_o);
   c_host_busy: cover property (@(posedge mclk_i) disable iff (rst_i) host_wr_mode && drawing_busy_i);

endmodule : rmc_top

// ===== verification/rmc_list_model.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Display-list writer and drawing engine stand-in
// -----------------------------------------------------------------
module rmc_list_model (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // List write and drawing status
   output logic dl_wr_o,
   output logic [15:0] dl_wdata_o,
   output logic drawing_busy_o
);
   // Idle values at time zero
   initial begin
      dl_wr_o = 1'b0;
      dl_wdata_o = 16'h0000;
      drawing_busy_o = 1'b0;
   end
   // reserved bits zero
   // One-cycle list write, stale data inverted once the strobe drops
   task automatic list_write(input logic [15:0] d);
      @(posedge mclk_i);
      dl_wr_o <= 1'b1;
      dl_wdata_o <= d & rmc_pkg::RMC_MODE_MASK;
      @(posedge mclk_i);
      dl_wr_o <= 1'b0;
      dl_wdata_o <= ~(d & rmc_pkg::RMC_MODE_MASK);
   endtask : list_write
   // drawing window
   // Drawing engine busy level
   task automatic set_busy(input logic b);
      @(posedge mclk_i);
      drawing_busy_o <= b & ~rst_i;
   endtask : set_busy
endmodule : rmc_list_model

// ===== verification/tb.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Rendering mode control bench
// -----------------------------------------------------------------
module tb;
   logic mclk_i, rst_i, psel, penable, pwrite, pready, pslverr, rerr, dl_wr, busy;
   logic sel, wid, fg, bg, rnd, conflict;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat, ex;
   logic [15:0] dl_wdata;
   logic [23:0] dsp, drw, base;
   logic [10:0] lw;
   logic [2:0] md, pixel_depth_mode;
   int bad_count, total_checks, m;
   localparam logic [11:0] MA = rmc_pkg::RMC_MODE_ADDR;
   localparam logic [11:0] SA = rmc_pkg::RMC_STAT_ADDR;

   rmc_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .dl_wr_i(dl_wr), .dl_wdata_i(dl_wdata), .drawing_busy_i(busy), .display_start_addr_i(dsp),
      .drawing_start_addr_i(drw), .drawing_addr_select_o(sel), .memory_width_select_o(wid),
      .pixel_depth_mode_o(pixel_depth_mode), .logical_width_o(lw), .draw_base_addr_o(base), .fg_16bpp_o(fg),
      .bg_16bpp_o(bg), .render_16bpp_o(rnd), .config_conflict_o(conflict));
   rmc_list_model u_list (.mclk_i(mclk_i), .rst_i(rst_i), .dl_wr_o(dl_wr), .dl_wdata_o(dl_wdata),
      .drawing_busy_o(busy));

   // Clock
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   // APB transfer: setup, access held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      do @(posedge mclk_i); while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Verdict
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   // Watchdog
   initial begin
      repeat (5000) @(posedge mclk_i);
      bad_count++;
      summarize();
   end
   // Main sequence
   initial begin
      rst_i = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      dsp = 24'h123456;
      drw = 24'hABCDEF;
      repeat (16) @(posedge mclk_i);
      rst_i <= 1'b0;
      apb(1'b0, MA, 32'h0);
      chk(rdat & 32'h8000, 32'h0);
      // Every depth mode, reserved bits written as ones
      for (m = 0; m < 8; m++) begin
         md = m[2:0];
         ex = {16'h0000, md[2] | md[1], 8'h00, md[1] ^ md[2], 3'b000, md};
         apb(1'b1, MA, ex | 32'hFFFF7FB8);
         @(negedge mclk_i);
         chk({29'h0, fg, bg, rnd}, {29'h0, md[0], md[0] ^ md[1], md[0] ^ md[2]});
         chk({21'h0, lw}, {21'h0, ex[6] ? 11'h400 : 11'h200});
         chk({31'h0, conflict}, 32'h0);
         chk({27'h0, sel, wid, pixel_depth_mode}, {27'h0, ex[15], ex[6], md});
         @(negedge mclk_i);
         chk({8'h0, base}, {8'h0, ex[15] ? drw : dsp});
         apb(1'b0, MA, 32'h0);
         chk(rdat, ex);
      end
      // Reset in mid-run keeps width and depth
      apb(1'b1, MA, 32'h8045);
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
      apb(1'b0, MA, 32'h0);
      chk(rdat, 32'h0045);
      chk({8'h0, base}, {8'h0, dsp});
      // Inconsistent select flagged, unmapped access refused
      apb(1'b1, MA, 32'h0004);
      @(negedge mclk_i);
      chk({31'h0, conflict}, 32'h1);
      chk({27'h0, sel, wid, pixel_depth_mode}, 32'h4);
      apb(1'b1, 12'h100, 32'hFFFFFFFF);
      apb(1'b0, 12'h100, 32'h0);
      chk({rdat[30:0], rerr}, 32'h1);
      apb(1'b0, SA, 32'h0);
      chk(rdat, 32'h4);
      // Writes while drawing
      apb(1'b1, MA, 32'h0001);
      u_list.set_busy(1'b1);
      u_list.list_write(16'h8005);
      apb(1'b0, SA, 32'h0);
      chk(rdat, 32'h8);
      chk({27'h0, sel, wid, pixel_depth_mode}, 32'h15);
      apb(1'b0, MA, 32'h0);
      chk(rdat, 32'h8005);
      u_list.list_write(16'h8045);
      apb(1'b0, SA, 32'h0);
      chk(rdat, 32'hA);
      apb(1'b1, MA, 32'h8045);
      apb(1'b0, SA, 32'h0);
      chk(rdat, 32'hB);
      apb(1'b1, SA, 32'h3);
      apb(1'b0, SA, 32'h0);
      chk(rdat, 32'h8);
      u_list.set_busy(1'b0);
      apb(1'b0, SA, 32'h0);
      chk(rdat, 32'h0);
      summarize();
   end
endmodule : tb
